/* File: mhrp_cfg.svh */
// Constants for the management host register port.
`ifndef MHRP_CFG_SVH
`define MHRP_CFG_SVH
`define MHRP_ADDR_W         7
`define MHRP_DATA_W         8
`define MHRP_BUS_IDLE       8'hFF
`define MHRP_STYLE_SEPARATE 1'b1
`define MHRP_STYLE_DSTROBE  1'b0
`define MHRP_CLK_PERIOD_NS  100
`define MHRP_RESET_MIN_NS   1000
`define MHRP_RESET_CYC      ((`MHRP_RESET_MIN_NS + `MHRP_CLK_PERIOD_NS - 1) / `MHRP_CLK_PERIOD_NS)
`define MHRP_SYNC_BITS      3
`define MHRP_SYNC_CS        2
`define MHRP_SYNC_A         1
`define MHRP_SYNC_B         0
`endif

/* File: mhrp_pkg.sv */
// Types shared by both ends of the management host register port.
`default_nettype none
`include "mhrp_cfg.svh"
package mhrp_pkg;
  typedef logic [`MHRP_ADDR_W-1:0] mhrp_addr_t;
  typedef logic [`MHRP_DATA_W-1:0] mhrp_data_t;
  typedef enum logic [5:0]
  {
    DEV_IDLE     = 6'h01,
    DEV_RD_FETCH = 6'h02,
    DEV_RD_CAPT  = 6'h04,
    DEV_RD_DRIVE = 6'h08,
    DEV_WR_PUT   = 6'h10,
    DEV_DONE     = 6'h20
  } mhrp_dev_state_t;
  typedef enum logic [4:0]
  {
    HST_RESET   = 5'h01,
    HST_IDLE    = 5'h02,
    HST_SETUP   = 5'h04,
    HST_STROBE  = 5'h08,
    HST_RELEASE = 5'h10
  } mhrp_hst_state_t;
endpackage
`default_nettype wire

/* File: mhrp_if.sv */
// Pin-level carrier between the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
`include "mhrp_cfg.svh"
interface mhrp_if;
  logic                    busStyleSelect;
  logic [`MHRP_ADDR_W-1:0] regAddrBus;
  logic                    csN;
  logic                    strobeAN;
  logic                    strobeBN;
  logic [`MHRP_DATA_W-1:0] hostDataOut;
  logic                    hostDataOe;
  logic [`MHRP_DATA_W-1:0] devDataOut;
  logic                    devDataOe;
  logic [`MHRP_DATA_W-1:0] regDataBus;
  logic                    doneDrv;
  logic                    doneOe;
  logic                    doneN;
  logic                    hostIrqN;
  logic                    sysResetN;

  // Released lines are modelled as pulled high.
  assign regDataBus = devDataOe ? devDataOut : (hostDataOe ? hostDataOut : `MHRP_BUS_IDLE);
  assign doneN      = doneOe ? doneDrv : 1'b1;

  modport device
  (
    input  busStyleSelect,
    input  regAddrBus,
    input  csN,
    input  strobeAN,
    input  strobeBN,
    input  regDataBus,
    output devDataOut,
    output devDataOe,
    output doneDrv,
    output doneOe,
    output hostIrqN
  );
  modport host
  (
    output busStyleSelect,
    output regAddrBus,
    output csN,
    output strobeAN,
    output strobeBN,
    output hostDataOut,
    output hostDataOe,
    input  regDataBus,
    input  doneN,
    input  hostIrqN,
    output sysResetN
  );
endinterface
`default_nettype wire

/* File: mhrp_device.sv */
// Device end of the management host register port.
`timescale 1ns/1ps
`default_nettype none
`include "mhrp_cfg.svh"
module mhrp_device
  import mhrp_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  mhrp_if.device                       bus,
  output logic     [`MHRP_ADDR_W-1:0] regAddr,
  output logic                         regRdEn,
  output logic                         regWrEn,
  output logic     [`MHRP_DATA_W-1:0] regWrData,
  input  wire logic [`MHRP_DATA_W-1:0] regRdData,
  input  wire logic                    irqPending,
  output logic                         styleSeparate
);

  mhrp_dev_state_t         state_r;
  mhrp_dev_state_t         state_nxt;
  logic                    style_r;
  logic                    styleTaken_r;
  logic [`MHRP_SYNC_BITS-1:0] syncMeta_r;
  logic [`MHRP_SYNC_BITS-1:0] syncOut_r;
  logic [`MHRP_SYNC_BITS-1:0] rawIn;
  logic                    csS;
  logic                    aS;
  logic                    bS;
  logic                    accessReq;
  logic                    readReq;
  logic                    strobeIdle;
  logic [`MHRP_ADDR_W-1:0] addr_r;
  logic [`MHRP_DATA_W-1:0] wrData_r;
  logic [`MHRP_DATA_W-1:0] rdData_r;
  logic                    rdEn_r;
  logic                    wrEn_r;
  logic                    readDrive_r;
  logic                    irqN_r;

  // The strap is static, so it is caught once on the first edge after reset release.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      style_r      <= `MHRP_STYLE_DSTROBE;
      styleTaken_r <= 1'b0;
    end
    else if (!styleTaken_r)
    begin
      style_r      <= bus.busStyleSelect;
      styleTaken_r <= 1'b1;
    end
  end

  assign rawIn[`MHRP_SYNC_CS] = bus.csN;
  assign rawIn[`MHRP_SYNC_A]  = bus.strobeAN;
  assign rawIn[`MHRP_SYNC_B]  = bus.strobeBN;

  // Strobes and select are asynchronous to this clock; two stages each.
  genvar gi;
  generate
    for (gi = 0; gi < `MHRP_SYNC_BITS; gi = gi + 1)
    begin : gSync
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          syncMeta_r[gi] <= 1'b1;
          syncOut_r[gi]  <= 1'b1;
        end
        else
        begin
          syncMeta_r[gi] <= rawIn[gi];
          syncOut_r[gi]  <= syncMeta_r[gi];
        end
      end
    end
  endgenerate

  assign csS = syncOut_r[`MHRP_SYNC_CS];
  assign aS  = syncOut_r[`MHRP_SYNC_A];
  assign bS  = syncOut_r[`MHRP_SYNC_B];

  // Separate style: A is the read strobe, B the write strobe.
  // Data-strobe style: A is the data strobe, B the direction line.
  always_comb
  begin
    if (style_r == `MHRP_STYLE_SEPARATE)
    begin
      accessReq  = !csS && (!aS || !bS);
      readReq    = !aS;
      strobeIdle = aS && bS;
    end
    else
    begin
      accessReq  = !csS && !aS;
      readReq    = bS;
      strobeIdle = aS;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      DEV_IDLE:
      begin
        if (accessReq && readReq)
          state_nxt = DEV_RD_FETCH;
        else if (accessReq)
          state_nxt = DEV_WR_PUT;
      end
      DEV_RD_FETCH: state_nxt = DEV_RD_CAPT;
      DEV_RD_CAPT:  state_nxt = DEV_RD_DRIVE;
      DEV_RD_DRIVE: state_nxt = DEV_DONE;
      DEV_WR_PUT:   state_nxt = DEV_DONE;
      DEV_DONE:
      begin
        if (strobeIdle || csS)
          state_nxt = DEV_IDLE;
      end
      default:      state_nxt = DEV_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      state_r <= DEV_IDLE;
    else
      state_r <= state_nxt;
  end

  // Address and write data are taken at the decision edge, three edges after the
  // strobe arrived, so the host's setup is already settled.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_r   <= '0;
      wrData_r <= '0;
    end
    else if (state_r == DEV_IDLE && accessReq)
    begin
      addr_r <= bus.regAddrBus;
      if (!readReq)
        wrData_r <= bus.regDataBus;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdEn_r <= 1'b0;
      wrEn_r <= 1'b0;
    end
    else
    begin
      rdEn_r <= (state_r == DEV_IDLE) && accessReq && readReq;
      wrEn_r <= (state_r == DEV_IDLE) && accessReq && !readReq;
    end
  end

  // Register core answers one cycle after the read pulse.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rdData_r <= '0;
    else if (state_r == DEV_RD_CAPT)
      rdData_r <= regRdData;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      readDrive_r <= 1'b0;
    else if (state_r == DEV_RD_CAPT)
      readDrive_r <= 1'b1;
    else if (state_r == DEV_DONE && state_nxt == DEV_IDLE)
      readDrive_r <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irqN_r <= 1'b1;
    else
      irqN_r <= !irqPending;
  end

  // The raw select gates the drivers so the bus is freed at once when the host
  // deselects, without waiting for the synchroniser.
  assign bus.devDataOut = rdData_r;
  assign bus.devDataOe  = readDrive_r && !bus.csN;
  assign bus.doneDrv    = 1'b0;
  assign bus.doneOe     = (state_r == DEV_DONE) && !bus.csN;
  assign bus.hostIrqN   = irqN_r;

  assign regAddr       = addr_r;
  assign regRdEn       = rdEn_r;
  assign regWrEn       = wrEn_r;
  assign regWrData     = wrData_r;
  assign styleSeparate = style_r;

endmodule
`default_nettype wire

/* File: mhrp_host.sv */
// Host end of the management host register port.
`timescale 1ns/1ps
`default_nettype none
`include "mhrp_cfg.svh"
module mhrp_host
  import mhrp_pkg::*;
#(
  parameter int RESET_CYC = `MHRP_RESET_CYC
)
(
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  mhrp_if.host                         bus,
  input  wire logic                    styleSel,
  input  wire logic                    reqValid,
  input  wire logic                    reqWrite,
  input  wire logic [`MHRP_ADDR_W-1:0] reqAddr,
  input  wire logic [`MHRP_DATA_W-1:0] reqWdata,
  output logic                         reqReady,
  output logic                         rspValid,
  output logic     [`MHRP_DATA_W-1:0] rspRdata,
  output logic                         irqSeen
);

  mhrp_hst_state_t         state_r;
  logic [7:0]              rstCnt_r;
  logic                    sysResetN_r;
  logic                    csN_r;
  logic                    strobeA_r;
  logic                    strobeB_r;
  logic                    write_r;
  logic [`MHRP_ADDR_W-1:0] addr_r;
  logic [`MHRP_DATA_W-1:0] wdata_r;
  logic [`MHRP_DATA_W-1:0] rdata_r;
  logic                    rspValid_r;

  // Reset pulse of at least the minimum width; the port clock is this clock and
  // keeps running through it.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstCnt_r    <= 8'h00;
      sysResetN_r <= 1'b0;
    end
    else if (rstCnt_r < RESET_CYC[7:0])
      rstCnt_r <= rstCnt_r + 8'h01;
    else
      sysResetN_r <= 1'b1;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r    <= HST_RESET;
      csN_r      <= 1'b1;
      strobeA_r  <= 1'b1;
      strobeB_r  <= 1'b1;
      write_r    <= 1'b0;
      addr_r     <= '0;
      wdata_r    <= '0;
      rdata_r    <= '0;
      rspValid_r <= 1'b0;
    end
    else
    begin
      rspValid_r <= 1'b0;
      case (state_r)
        HST_RESET:
        begin
          if (sysResetN_r)
            state_r <= HST_IDLE;
        end
        HST_IDLE:
        begin
          if (reqValid)
          begin
            addr_r    <= reqAddr;
            wdata_r   <= reqWdata;
            write_r   <= reqWrite;
            csN_r     <= 1'b0;
            strobeB_r <= styleSel ? 1'b1 : !reqWrite;
            state_r   <= HST_SETUP;
          end
        end
        HST_SETUP:
        begin
          if (styleSel && write_r)
            strobeB_r <= 1'b0;
          else
            strobeA_r <= 1'b0;
          state_r <= HST_STROBE;
        end
        HST_STROBE:
        begin
          if (!bus.doneN)
          begin
            if (!write_r)
              rdata_r <= bus.regDataBus;
            rspValid_r <= 1'b1;
            strobeA_r  <= 1'b1;
            strobeB_r  <= 1'b1;
            state_r    <= HST_RELEASE;
          end
        end
        HST_RELEASE:
        begin
          if (bus.doneN)
          begin
            csN_r   <= 1'b1;
            state_r <= HST_IDLE;
          end
        end
        default: state_r <= HST_IDLE;
      endcase
    end
  end

  assign bus.busStyleSelect = styleSel;
  assign bus.regAddrBus     = addr_r;
  assign bus.csN            = csN_r;
  assign bus.strobeAN       = strobeA_r;
  assign bus.strobeBN       = strobeB_r;
  assign bus.hostDataOut    = wdata_r;
  assign bus.hostDataOe     = write_r && !csN_r;
  assign bus.sysResetN      = sysResetN_r;

  assign reqReady = (state_r == HST_IDLE);
  assign rspValid = rspValid_r;
  assign rspRdata = rdata_r;
  assign irqSeen  = !bus.hostIrqN;

endmodule
`default_nettype wire

/* File: mhrp_props.sv */
// Concurrent checks on the pins between the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
`include "mhrp_cfg.svh"
module mhrp_props
(
  input wire logic                    core_clk,
  input wire logic                    resetn,
  input wire logic                    busStyleSelect,
  input wire logic [`MHRP_ADDR_W-1:0] regAddrBus,
  input wire logic                    csN,
  input wire logic                    strobeAN,
  input wire logic                    strobeBN,
  input wire logic                    hostDataOe,
  input wire logic                    devDataOe,
  input wire logic                    doneOe,
  input wire logic                    doneN,
  input wire logic                    sysResetN
);
  logic strbAct;
  logic rdAct;
  logic wrAct;

  localparam int RST_MIN = `MHRP_RESET_CYC;
  logic [7:0] rstLow_r = 8'h00;

  // Low cycles of the system reset are counted so its width can be judged at release.
  always @(posedge core_clk)
  begin
    if (sysResetN)
      rstLow_r <= 8'h00;
    else if (rstLow_r != 8'hFF)
      rstLow_r <= rstLow_r + 8'h01;
  end

  assign strbAct = busStyleSelect ? !(strobeAN && strobeBN) : !strobeAN;
  assign rdAct   = !csN && (busStyleSelect ? !strobeAN : (!strobeAN && strobeBN));
  assign wrAct   = !csN && (busStyleSelect ? !strobeBN : (!strobeAN && !strobeBN));

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence sStart;
    $rose(strbAct) && !csN;
  endsequence
  sequence sAnswer;
    ##[2:12] !doneN;
  endsequence
  sequence sRelease;
    $fell(strbAct) && !doneN;
  endsequence

  // The completion has to come within a bounded wait, including the strobe sync stages.
  chk_done_latency: assert property (sStart |-> sAnswer)
    else $error("completion late after strobe");
  chk_done_release: assert property (sRelease |-> ##[1:5] doneN)
    else $error("completion held after strobe release");
  chk_cs_gates: assert property (csN |-> !doneOe && !devDataOe)
    else $error("driver active with chip select high");
  chk_done_cause: assert property ($fell(doneN) |-> !csN && $past(strbAct, 2))
    else $error("completion without synchronised strobe");
  chk_read_drive: assert property (rdAct && !doneN |-> devDataOe)
    else $error("read completed without data drive");
  chk_write_quiet: assert property (wrAct |-> !devDataOe && hostDataOe)
    else $error("bus contention on write");
  chk_one_strobe: assert property (busStyleSelect |-> strobeAN || strobeBN)
    else $error("read and write strobes together");
  chk_addr_hold: assert property (strbAct && $past(strbAct) |->
    $stable(regAddrBus) && (busStyleSelect || $stable(strobeBN)))
    else $error("address or direction moved in access");
  chk_strobe_cs: assert property (strbAct |-> !csN)
    else $error("strobe without chip select");
  chk_reset_quiet: assert property (!sysResetN |-> csN && strobeAN && strobeBN)
    else $error("access during system reset");
  chk_reset_width: assert property ($rose(sysResetN) |-> rstLow_r >= RST_MIN)
    else $error("system reset pulse too short");
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench joining the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
`include "mhrp_cfg.svh"
module testbench
  import mhrp_pkg::*;
;
  // The system reset keeps its full minimum width so the host end obeys the reset rule.
  localparam int RST_CYC = `MHRP_RESET_CYC;
  logic       core_clk   = 1'b0;
  logic       resetn     = 1'b0;
  logic       styleSel   = 1'b0;
  logic       reqValid   = 1'b0;
  logic       reqWrite   = 1'b0;
  logic       irqPending = 1'b0;
  mhrp_addr_t reqAddr    = '0;
  mhrp_data_t reqWdata   = '0;
  logic       reqReady, rspValid, irqSeen, regRdEn, regWrEn, styleSeparate;
  mhrp_data_t rspRdata, regWrData, regRdData;
  mhrp_addr_t regAddr;
  mhrp_data_t mem [128];
  int         mismatches  = 0;
  int         totalChecks = 0;
  int         rdPulses    = 0;
  int         wrPulses    = 0;

  always #50 core_clk = ~core_clk;

  mhrp_if bus ();
  mhrp_host #(.RESET_CYC(RST_CYC)) mhrp_host_i (.core_clk(core_clk), .resetn(resetn),
    .bus(bus), .styleSel(styleSel), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid),
    .rspRdata(rspRdata), .irqSeen(irqSeen));
  mhrp_device mhrp_device_i (.core_clk(core_clk), .resetn(bus.sysResetN), .bus(bus),
    .regAddr(regAddr), .regRdEn(regRdEn), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdData(regRdData), .irqPending(irqPending), .styleSeparate(styleSeparate));
  mhrp_props mhrp_props_i (.core_clk(core_clk), .resetn(resetn),
    .busStyleSelect(bus.busStyleSelect), .regAddrBus(bus.regAddrBus), .csN(bus.csN),
    .strobeAN(bus.strobeAN), .strobeBN(bus.strobeBN), .hostDataOe(bus.hostDataOe),
    .devDataOe(bus.devDataOe), .doneOe(bus.doneOe), .doneN(bus.doneN),
    .sysResetN(bus.sysResetN));

  assign regRdData = mem[regAddr];
  always @(posedge core_clk)
  begin
    if (regWrEn === 1'b1)
      mem[regAddr] <= regWrData;
    if (regWrEn === 1'b1)
      wrPulses <= wrPulses + 1;
    if (regRdEn === 1'b1)
      rdPulses <= rdPulses + 1;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check_byte(input mhrp_data_t got, input mhrp_data_t exp, input string msg);
    totalChecks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string msg);
    check_byte({7'h00, got}, {7'h00, exp}, msg);
  endtask

  // Bounded wait for a level, sampled just after each edge.
  task automatic wait_val(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 50)
    begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask

  task automatic do_reset(input logic style);
    int  n;
    time t0;
    resetn   = 1'b0;
    styleSel = style;
    repeat (5) @(posedge core_clk);
    #1 resetn = 1'b1;
    t0 = $time;
    n  = 0;
    while (bus.sysResetN !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    check_bit(($time - t0) >= `MHRP_RESET_MIN_NS, 1'b1, "reset pulse width");
    while (reqReady !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    check_bit(n > RST_CYC, 1'b1, "reset hold too short");
    check_bit(styleSeparate, style, "style strap");
    check_bit(bus.busStyleSelect, style, "style pin");
    check_byte(bus.regDataBus, `MHRP_BUS_IDLE, "idle data bus");
    check_bit(bus.doneN, 1'b1, "idle completion");
    check_bit(bus.hostIrqN, 1'b1, "idle interrupt");
  endtask

  task automatic xfer(input logic wr, input mhrp_addr_t a, input mhrp_data_t d,
                      output mhrp_data_t rd);
    wait_val(reqReady, 1'b1);
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr  = a;
    reqWdata = d;
    @(posedge core_clk);
    #1 reqValid = 1'b0;
    wait_val(rspValid, 1'b1);
    check_bit(rspValid, 1'b1, "no completion");
    rd = rspRdata;
  endtask

  task automatic test_rw(input logic style);
    mhrp_addr_t a [3] = '{7'h00, 7'h7F, 7'h2A};
    mhrp_data_t d [3] = '{8'hA5, 8'h00, 8'h5A};
    mhrp_data_t rd;
    mhrp_data_t flip;
    int         rd0;
    int         wr0;
    do_reset(style);
    // Each style writes its own pattern, so a dead write cannot hide behind old data.
    flip = style ? 8'h3C : 8'h00;
    wr0  = wrPulses;
    foreach (a[i])
    begin
      xfer(1'b1, a[i], d[i] ^ flip, rd);
      check_byte(mem[a[i]], d[i] ^ flip, "write data");
    end
    check_byte(8'(wrPulses - wr0), 8'h03, "write pulses");
    rd0 = rdPulses;
    foreach (a[i])
    begin
      xfer(1'b0, a[i], 8'h00, rd);
      check_byte(rd, d[i] ^ flip, "read data");
    end
    check_byte(8'(rdPulses - rd0), 8'h03, "read pulses");
  endtask

  task automatic test_irq();
    irqPending = 1'b1;
    wait_val(irqSeen, 1'b1);
    check_bit(bus.hostIrqN, 1'b0, "interrupt raised");
    irqPending = 1'b0;
    wait_val(irqSeen, 1'b0);
    check_bit(bus.hostIrqN, 1'b1, "interrupt cleared");
  endtask

  initial
  begin
    test_rw(`MHRP_STYLE_DSTROBE);
    test_rw(`MHRP_STYLE_SEPARATE);
    test_irq();
    report_and_stop();
  end

  // The tests need well under a tenth of this span.
  initial
  begin
    #2000000;
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
